// *** rtl/ccrb_device.sv ***
// codec control register bank: serial frame slave and registers
//
// Overview of operation
// - frame bits 15..12 address the register
// - bit 11 high reads, low writes
// - host always sends zero in bit 10
// - bits 9..0 carry write value or read data
// - fifteen registers, two peak registers read-only
// - ten-bit registers, peak in upper six bits
// - peak holds smallest recent 6-bit attenuation code
// - reading a peak register clears it
// - peak capture only when the peak enable bit is set
// - eight volume registers, default 1023
// - dac controls then volumes at lowest addresses
// - dac rate field bits 1:0 decoded
// - host sets master clock scaling correctly
// - dac power-down bit 2, digital only
// - dac word width field bits 4:3
// - dac format field bits 7:5, 010 dsp
// - de-emphasis field bits 9:8
// - per-channel mute bits drive soft mute
// - replicate feeds pair one to all
// - adc rate bit selects 48 or 96k
// - adc power-down bit, digital only
// - adc high-pass filter enable bit
// - peak read low four bits zero
`timescale 1ns/1ps
module ccrb_device
	import ccrb_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst_b,
	ccrb_link_if.device     link,
	input  wire logic       peak_valid,
	input  wire logic [5:0] peak_left,
	input  wire logic [5:0] peak_right,
	output logic [1:0]      dac_rate,
	output logic            dac_powerdown,
	output logic [1:0]      dac_width,
	output logic [2:0]      dac_format,
	output logic [1:0]      deemphasis,
	output logic [7:0]      dac_mute,
	output logic            stereo_replicate,
	output logic [79:0]     volume_flat,
	output logic            adc_rate,
	output logic            adc_powerdown,
	output logic            adc_highpass,
	output logic [1:0]      mclk_scale
);
	import ccrb_pkg::*;

	// ============================================================
	// link input synchronisers
	logic cs_s;
	logic sclk_s;
	logic mosi_s;
	ccrb_sync #(.RST_VAL(1'b1)) u_cs
		(.mclk(mclk), .rst_b(rst_b), .din(link.cs_n), .dout(cs_s));
	ccrb_sync #(.RST_VAL(1'b1)) u_sclk
		(.mclk(mclk), .rst_b(rst_b), .din(link.sclk), .dout(sclk_s));
	ccrb_sync #(.RST_VAL(1'b1)) u_mosi
		(.mclk(mclk), .rst_b(rst_b), .din(link.mosi), .dout(mosi_s));

	logic sclk_prev_q;
	wire  rise = sclk_s & ~sclk_prev_q;
	wire  fall = ~sclk_s & sclk_prev_q;

	// ============================================================
	// registers
	logic [9:0]  ctrl_q [0:15];
	logic [5:0]  peak_l_q;
	logic [5:0]  peak_r_q;
	logic [15:0] shift_q;
	logic [4:0]  cnt_q;
	logic [9:0]  rdata_q;
	logic        miso_q;
	logic        held_l_q;
	logic        held_r_q;

	// at the fifth rise the direction bit is still on the wire, not in the shifter
	wire       rd_w     = mosi_s;
	wire       last_bit = rise & ~cs_s & (cnt_q == 5'd15);
	wire [15:0] frame_w = {shift_q[14:0], mosi_s};
	wire [3:0]  f_addr  = frame_w[ADDR_HI:ADDR_LO];
	wire        f_rd    = frame_w[RW_BIT];
	wire [9:0]  f_data  = frame_w[DATA_BITS-1:0];
	// writes to peak or reserved slot are dropped
	wire f_wr_ok = last_bit & ~f_rd & (f_addr != A_PEAKL) & (f_addr != A_PEAKR)
		& (f_addr != A_RSVD);
	// read data is latched once address and direction are in (after 5 bits)
	wire addr_done = rise & ~cs_s & (cnt_q == 5'd4);
	wire [3:0] ra_w = shift_q[3:0];
	wire peak_en = ctrl_q[A_ADC3][F_PEAK_EN];
	wire clr_l = addr_done & rd_w & (ra_w == A_PEAKL);
	wire clr_r = addr_done & rd_w & (ra_w == A_PEAKR);
	wire [9:0] rd_mux = (ra_w == A_PEAKL) ? {peak_l_q, 4'h0} :
		(ra_w == A_PEAKR) ? {peak_r_q, 4'h0} :
		(ra_w == A_RSVD)  ? 10'h000 : ctrl_q[ra_w];
	// a sample in the cycle of a clearing read wins, so no peak is lost
	wire cap_l = peak_en & peak_valid & (clr_l | ~held_l_q | (peak_left < peak_l_q));
	wire cap_r = peak_en & peak_valid & (clr_r | ~held_r_q | (peak_right < peak_r_q));

	// frame shifter; a deasserted select abandons a partial frame
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sclk_prev_q <= 1'b1;
			shift_q     <= 16'h0000;
			cnt_q       <= 5'h00;
		end
		else
		begin
			sclk_prev_q <= sclk_s;
			if (cs_s)
				cnt_q <= 5'h00;
			else if (rise)
			begin
				shift_q <= frame_w;
				cnt_q   <= (cnt_q == 5'd15) ? 5'h00 : cnt_q + 5'd1;
			end
		end
	end

	// register array; volumes default to full scale
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < 16; i++)
				ctrl_q[i] <= (i >= 2 && i <= 9) ? RST_VOL : RST_CTRL;
		end
		else if (f_wr_ok)
			ctrl_q[f_addr] <= f_data;
	end

	// peak hold keeps the smallest attenuation code, i.e. the loudest result;
	// a cleared held flag marks an empty register, since code 0 is itself a valid 0 dB peak
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			peak_l_q <= RST_PEAK;
			peak_r_q <= RST_PEAK;
			held_l_q <= 1'b0;
			held_r_q <= 1'b0;
		end
		else
		begin
			if (cap_l)
			begin
				peak_l_q <= peak_left;
				held_l_q <= 1'b1;
			end
			else if (clr_l)
			begin
				peak_l_q <= RST_PEAK;
				held_l_q <= 1'b0;
			end
			if (cap_r)
			begin
				peak_r_q <= peak_right;
				held_r_q <= 1'b1;
			end
			else if (clr_r)
			begin
				peak_r_q <= RST_PEAK;
				held_r_q <= 1'b0;
			end
		end
	end

	// read shift-out on falling bit clock edges during bits 9..0
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rdata_q <= 10'h000;
			miso_q  <= 1'b0;
		end
		else
		begin
			if (addr_done)
				rdata_q <= rd_mux;
			if (cs_s)
				miso_q <= 1'b0;
			else if (fall && cnt_q >= 5'd6)
			begin
				miso_q  <= rdata_q[9];
				rdata_q <= {rdata_q[8:0], 1'b0};
			end
		end
	end
	assign link.miso = miso_q;

	// ============================================================
	// configuration outputs, registered
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dac_rate <= 2'h0; dac_powerdown <= 1'b0; dac_width <= 2'h0;
			dac_format <= 3'h0; deemphasis <= 2'h0; dac_mute <= 8'h00;
			stereo_replicate <= 1'b0; volume_flat <= {8{RST_VOL}};
			adc_rate <= 1'b0; adc_powerdown <= 1'b0; adc_highpass <= 1'b0;
			mclk_scale <= 2'h0;
		end
		else
		begin
			dac_rate      <= ctrl_q[A_DAC1][F_DAC_RATE +: 2];
			dac_powerdown <= ctrl_q[A_DAC1][F_DAC_PD];
			dac_width     <= ctrl_q[A_DAC1][F_DAC_WIDTH +: 2];
			dac_format    <= ctrl_q[A_DAC1][F_DAC_FMT +: 3];
			deemphasis    <= ctrl_q[A_DAC1][F_DEEMPH +: 2];
			dac_mute      <= ctrl_q[A_DAC2][7:0];
			stereo_replicate <= ctrl_q[A_DAC2][F_REPLICATE];
			for (int v = 0; v < 8; v++)
				volume_flat[v*10 +: 10] <= ctrl_q[v+2];
			adc_rate      <= ctrl_q[A_ADC1][F_ADC_RATE];
			adc_powerdown <= ctrl_q[A_ADC1][F_ADC_PD];
			adc_highpass  <= ctrl_q[A_ADC1][F_ADC_HPF];
			mclk_scale    <= ctrl_q[A_ADC3][F_MCLK_SCALE +: 2];
		end
	end
endmodule

// *** rtl/ccrb_pkg.sv ***
// shared constants for the codec control register bank
package ccrb_pkg;
	localparam int FRAME_BITS      = 16;
	localparam int ADDR_HI         = 15;
	localparam int ADDR_LO         = 12;
	localparam int RW_BIT          = 11;
	localparam int RES_BIT         = 10;
	localparam int DATA_BITS       = 10;
	localparam int PEAK_BITS       = 6;
	localparam int PEAK_LSB        = 4;
	localparam logic [3:0] A_DAC1  = 4'h0;
	localparam logic [3:0] A_DAC2  = 4'h1;
	localparam logic [3:0] A_VOL0  = 4'h2;
	localparam logic [3:0] A_VOL7  = 4'h9;
	localparam logic [3:0] A_PEAKL = 4'hA;
	localparam logic [3:0] A_PEAKR = 4'hB;
	localparam logic [3:0] A_ADC1  = 4'hC;
	localparam logic [3:0] A_ADC2  = 4'hD;
	localparam logic [3:0] A_ADC3  = 4'hE;
	localparam logic [3:0] A_RSVD  = 4'hF;
	localparam logic [9:0] RST_CTRL = 10'h000;
	localparam logic [9:0] RST_VOL  = 10'h3FF;
	localparam logic [5:0] RST_PEAK = 6'h00;
	// field positions
	localparam int F_DAC_RATE   = 0;
	localparam int F_DAC_PD     = 2;
	localparam int F_DAC_WIDTH  = 3;
	localparam int F_DAC_FMT    = 5;
	localparam int F_DEEMPH     = 8;
	localparam int F_REPLICATE  = 8;
	localparam int F_ADC_RATE   = 6;
	localparam int F_ADC_PD     = 7;
	localparam int F_ADC_HPF    = 8;
	localparam int F_PEAK_EN    = 5;
	localparam int F_MCLK_SCALE = 6;
	// host side: bit clock half period in mclk cycles (4 ns * 8 = 32 ns)
	localparam int HALF_SCLK_CYC = 8;
	// host-side user registers, own map
	localparam logic [1:0] H_CMD    = 2'h0;
	localparam logic [1:0] H_STATUS = 2'h1;
	localparam logic [1:0] H_RDATA  = 2'h2;
endpackage

// *** rtl/ccrb_link_if.sv ***
// serial control link between host and codec register bank
`timescale 1ns/1ps
interface ccrb_link_if;
	logic cs_n;
	logic sclk;
	logic mosi;
	logic miso;
	modport device (input cs_n, input sclk, input mosi, output miso);
	modport host (output cs_n, output sclk, output mosi, input miso);
endinterface

// *** rtl/ccrb_sync.sv ***
// two-flop synchroniser for link inputs
`timescale 1ns/1ps
module ccrb_sync
#(
	parameter logic RST_VAL = 1'b1
)
(
	input  wire logic mclk,
	input  wire logic rst_b,
	input  wire logic din,
	output logic      dout
);
	logic meta_q;
	// first stage only feeds the second; reset value is the pin's idle level,
	// so no false edge is seen when reset lets go
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			meta_q <= RST_VAL;
			dout   <= RST_VAL;
		end
		else
		begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule

// *** rtl/ccrb_host.sv ***
// host controller: drives 16-bit control frames from a simple register port
`timescale 1ns/1ps
module ccrb_host
	import ccrb_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst_b,
	ccrb_link_if.host        link,
	input  wire logic [1:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic [15:0]      rdata
);
	import ccrb_pkg::*;
	typedef enum logic [1:0] {hs_idle, hs_low, hs_high, hs_done} ccrb_hstate_type;
	ccrb_hstate_type st_q;
	logic [15:0] tx_q;
	logic [9:0]  rx_q;
	logic [4:0]  bit_q;
	logic [3:0]  div_q;
	logic        cs_q;
	logic        sclk_q;
	logic        miso_s;
	ccrb_sync #(.RST_VAL(1'b0)) u_miso
		(.mclk(mclk), .rst_b(rst_b), .din(link.miso), .dout(miso_s));
	wire tick  = (div_q == 4'(HALF_SCLK_CYC - 1));
	wire start = wr & (addr == H_CMD) & (st_q == hs_idle);
	// bit 10 forced zero; peak writes are the caller's to avoid
	wire [15:0] frame = {wdata[15:11], 1'b0, wdata[9:0]};
	assign link.cs_n = cs_q;
	assign link.sclk = sclk_q;
	assign link.mosi = tx_q[15];

	// frame sequencer: data changes on low phase, sampled on rise
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_q <= hs_idle; tx_q <= 16'h0000; rx_q <= 10'h000; bit_q <= 5'h00;
			div_q <= 4'h0; cs_q <= 1'b1; sclk_q <= 1'b1;
		end
		else
		begin
			div_q <= (st_q == hs_idle || tick) ? 4'h0 : div_q + 4'h1;
			unique case (st_q)
				hs_idle:
					if (start)
					begin
						tx_q <= frame; cs_q <= 1'b0; bit_q <= 5'h00; st_q <= hs_low;
					end
				hs_low:
					if (tick)
					begin
						sclk_q <= 1'b0;
						// next bit leaves on the fall, settled half a period before the rise
						if (bit_q != 5'd0)
							tx_q <= {tx_q[14:0], 1'b0};
						st_q <= hs_high;
					end
				hs_high:
					if (tick)
					begin
						sclk_q <= 1'b1;
						rx_q   <= {rx_q[8:0], miso_s};
						if (bit_q == 5'd15)
							st_q <= hs_done;
						else
						begin
							bit_q <= bit_q + 5'd1;
							st_q  <= hs_low;
						end
					end
				hs_done:
					if (tick)
					begin
						cs_q <= 1'b1; st_q <= hs_idle;
					end
			endcase
		end
	end

	// read port, data one cycle after strobe
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			rdata <= 16'h0000;
		else if (rd)
			rdata <= (addr == H_STATUS) ? {15'h0000, st_q != hs_idle} :
				(addr == H_RDATA) ? {6'h00, rx_q} : 16'h0000;
	end
endmodule

// *** testbench/ccrb_link_monitor.sv ***
// protocol checker for the serial control link
`timescale 1ns/1ps
module ccrb_link_monitor
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic miso
);
	import ccrb_pkg::*;
	logic [4:0] cnt_q;
	logic [4:0] hdr_q;
	logic       sclk_q;
	wire        rise_w    = sclk & ~sclk_q & ~cs_n;
	wire        peak_rd_w = hdr_q[0] & (hdr_q[4:1] == A_PEAKL | hdr_q[4:1] == A_PEAKR);
	// ====
	// bit count and header capture; the count clears whenever the frame ends
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt_q  <= 5'h00;
			hdr_q  <= 5'h00;
			sclk_q <= 1'b1;
		end
		else
		begin
			sclk_q <= sclk;
			cnt_q  <= cs_n ? 5'h00 : cnt_q + {4'h0, rise_w};
			if (rise_w && cnt_q < 5'h05)
				hdr_q <= {hdr_q[3:0], mosi};
		end
	end
	// ====
	// assertions
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	chk_idle_high: assert property (cs_n |-> sclk)
		else $error("bit clock low outside a frame");
	chk_low_width: assert property ($fell(sclk) |-> !sclk [*8])
		else $error("bit clock low phase too short");
	chk_mosi_stable: assert property ($rose(sclk) |-> $stable(mosi))
		else $error("host data moved at a rising bit clock");
	chk_res_zero: assert property (rise_w && cnt_q == 5'h05 |-> !mosi)
		else $error("reserved frame bit not zero");
	chk_frame_len: assert property ($rose(cs_n) |-> cnt_q == 5'h10)
		else $error("frame not sixteen bits long");
	chk_frame_end: assert property ($fell(cs_n) |-> ##[1:400] $rose(cs_n))
		else $error("frame never closed");
	chk_clock_start: assert property ($fell(cs_n) |-> sclk ##[1:16] !sclk)
		else $error("bit clock did not start");
	chk_peak_low: assert property (rise_w && peak_rd_w && cnt_q >= 5'h0C |-> !miso)
		else $error("peak read low bits not zero");
endmodule

// *** testbench/test_codec_control_register_bank.sv ***
// self-checking bench: host and register bank joined by the serial link
`timescale 1ns/1ps
module test_codec_control_register_bank;
	import ccrb_pkg::*;
	logic        mclk;
	logic        rst_b;
	logic [1:0]  addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic        peak_valid;
	logic [5:0]  peak_left;
	logic [5:0]  peak_right;
	logic [1:0]  dac_rate;
	logic        dac_powerdown;
	logic [1:0]  dac_width;
	logic [2:0]  dac_format;
	logic [1:0]  deemphasis;
	logic [7:0]  dac_mute;
	logic        stereo_replicate;
	logic [79:0] volume_flat;
	logic        adc_rate;
	logic        adc_powerdown;
	logic        adc_highpass;
	logic [1:0]  mclk_scale;
	logic [9:0]  r;
	logic [3:0]  wa [6];
	logic [9:0]  wd [6];
	int          err_count;
	int          compares;
	int          cyc;
	int          i;
	// ====
	// the two ends and the checker
	ccrb_link_if link();
	ccrb_host i_ccrb_host (.mclk(mclk), .rst_b(rst_b), .link(link), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	ccrb_device i_ccrb_device (.mclk(mclk), .rst_b(rst_b), .link(link),
		.peak_valid(peak_valid), .peak_left(peak_left), .peak_right(peak_right),
		.dac_rate(dac_rate), .dac_powerdown(dac_powerdown), .dac_width(dac_width),
		.dac_format(dac_format), .deemphasis(deemphasis), .dac_mute(dac_mute),
		.stereo_replicate(stereo_replicate), .volume_flat(volume_flat),
		.adc_rate(adc_rate), .adc_powerdown(adc_powerdown), .adc_highpass(adc_highpass),
		.mclk_scale(mclk_scale));
	ccrb_link_monitor u_mon (.mclk(mclk), .rst_b(rst_b), .cs_n(link.cs_n),
		.sclk(link.sclk), .mosi(link.mosi), .miso(link.miso));
	// ====
	// access tasks
	task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic bus_wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge mclk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge mclk);
		wr    <= 1'b0;
	endtask
	task automatic bus_rd(input logic [1:0] a, output logic [15:0] d);
		@(posedge mclk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge mclk);
		rd   <= 1'b0;
		#1;
		d = rdata;
	endtask
	// one whole frame; busy is polled with a bound so a stuck host cannot hang here
	task automatic frame(input logic [15:0] f, output logic [9:0] res);
		logic [15:0] s;
		bus_wr(H_CMD, f);
		s = 16'h0001;
		for (int n = 0; n < 200 && s[0]; n++)
			bus_rd(H_STATUS, s);
		bus_rd(H_RDATA, s);
		res = s[9:0];
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [9:0] exp, input string what);
		frame({a, 2'b10, 10'h000}, r);
		chk(r, exp, what);
	endtask
	task automatic pk(input logic [5:0] lv, input logic [5:0] rv);
		@(posedge mclk);
		peak_left  <= lv;
		peak_right <= rv;
		peak_valid <= 1'b1;
		@(posedge mclk);
		peak_valid <= 1'b0;
	endtask
	task automatic end_of_test;
		$display("mismatches %0d comparisons %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ====
	// clock and hang guard
	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			err_count++;
			$display("[FAIL] %0t run timed out", $time);
			end_of_test;
		end
	end
	// ====
	// scenarios
	initial
	begin
		{rst_b, addr, wdata, wr, rd, peak_valid, peak_left, peak_right} = '0;
		{err_count, compares, cyc} = '0;
		repeat (6) @(posedge mclk);
		rst_b <= 1'b1;
		for (i = 0; i < 15; i++)
			rd_chk(i[3:0], (i >= 2 && i <= 9) ? 10'h3FF : 10'h000, "reset");
		pk(6'h03, 6'h03);
		rd_chk(A_PEAKL, 10'h000, "peak while disabled");
		// bit 10 is offered high on purpose; the host must send it as zero
		wa = '{A_DAC1, A_DAC2, A_ADC1, A_ADC2, A_ADC3, A_PEAKL};
		wd = '{10'h24E, 10'h1A5, 10'h1C0, 10'h155, 10'h0E0, 10'h3FF};
		for (i = 0; i < 6; i++)
			frame({wa[i], 2'b01, wd[i]}, r);
		for (i = 0; i < 6; i++)
			rd_chk(wa[i], (i == 5) ? 10'h000 : wd[i], "readback");
		chk({1'b0, stereo_replicate, dac_mute}, 10'h1A5, "mute");
		chk({7'h00, adc_highpass, adc_powerdown, adc_rate}, 10'h007, "adc");
		chk({8'h00, mclk_scale}, 10'h003, "scaling");
		frame({A_RSVD, 2'b00, 10'h2AA}, r);
		rd_chk(A_RSVD, 10'h000, "reserved");
		for (i = 0; i < 4; i++)
		begin
			wd[0] = {i[1:0], 1'b0, i[1:0], i[1:0], i[0], i[1:0]};
			frame({A_DAC1, 2'b00, wd[0]}, r);
			chk({deemphasis, dac_format, dac_width, dac_powerdown, dac_rate}, wd[0], "dac");
		end
		for (i = 0; i < 8; i++)
		begin
			frame({A_VOL0 + 4'(i), 2'b00, 10'h100 + 10'(i)}, r);
			rd_chk(A_VOL0 + 4'(i), 10'h100 + 10'(i), "volume");
			chk(volume_flat[i*10 +: 10], 10'h100 + 10'(i), "volume out");
		end
		pk(6'h07, 6'h09);
		pk(6'h05, 6'h0C);
		rd_chk(A_PEAKL, 10'h050, "left peak");
		rd_chk(A_PEAKR, 10'h090, "right peak");
		rd_chk(A_PEAKL, 10'h000, "peak cleared");
		// a 0 dB result must survive later quieter ones
		pk(6'h00, 6'h3F);
		pk(6'h02, 6'h3E);
		rd_chk(A_PEAKL, 10'h000, "0 dB peak kept");
		rd_chk(A_PEAKR, 10'h3E0, "deep peak");
		end_of_test;
	end
endmodule
